// File: design/gbd_defs.svh
// Register offsets, field positions, masks and reset values of the gamma bank block.
`ifndef GBD_DEFS_SVH
`define GBD_DEFS_SVH

`define GBD_NUM_CHAN        11
`define GBD_NUM_BANK        4
`define GBD_ADDR_DIRECT     8'h00
`define GBD_ADDR_DIRECT_END 8'h0a
`define GBD_ADDR_BANK       8'h10
`define GBD_ADDR_BANK_END   8'h3b
`define GBD_ADDR_SW_BANK    8'h50
`define GBD_ADDR_STANDBY    8'h51
`define GBD_ADDR_STATUS     8'h57
`define GBD_ADDR_CTRL       8'h60
`define GBD_MASK_SW_BANK    8'h03
`define GBD_MASK_STANDBY    8'h01
`define GBD_MASK_CTRL       8'h33
`define GBD_RST_VOLATILE    8'h00
`define GBD_RST_BANK        8'h80
`define GBD_RST_CTRL        8'h10
`define GBD_CTRL_MODE_LSB   0
`define GBD_CTRL_BIAS_LSB   4
`define GBD_STANDBY_BIT     0
`define GBD_STATUS_LD_BIT   7
`define GBD_SLAVE_ADDR_HI   6'h30
`define GBD_PIN_IDLE        7'h60

`endif

// File: design/gbd_pkg.sv
// Types shared by the gamma bank control logic.
package gbd_pkg;

  typedef logic [7:0] gbd_code_t;

  typedef enum {
    GBD_IDLE,
    GBD_ADDR,
    GBD_ADDR_ACK,
    GBD_REG,
    GBD_REG_ACK,
    GBD_WDATA,
    GBD_WACK,
    GBD_RDATA,
    GBD_RACK
  } gbd_i2c_state_t;

  typedef struct packed {
    logic scl;
    logic sda;
    logic ld;
    logic bank_hi;
    logic bank_lo;
    logic addr_sel;
    logic hot;
  } gbd_pins_t;

  typedef struct packed {
    logic [10:0][7:0] code;
    logic             gamma_hiz;
    logic             common_hiz;
    logic [1:0]       bias;
  } gbd_dac_out_t;

endpackage : gbd_pkg

// File: design/gbd_top.sv
// Gamma and common-electrode DAC code control with an I2C register slave.
//
// Function
// - Control bits 1:0 choose operating mode.
// - Mode bits reset to pin bank select.
// - Each channel holds four bank bytes.
// - Select pins pick bank, high pin MSB.
// - Software mode uses select register, ignores pins.
// - Software select clears to bank A.
// - Strobe high makes output latch transparent.
// - Strobe low holds output codes.
// - Strobe rise updates all channels together.
// - Strobe fall captures selected data.
// - Direct mode uses per-channel value registers.
// - Direct writes reach outputs per strobe.
// - Value register writes have no delay.
// - Standby bit puts outputs high impedance.
// - Serial interface works during standby.
// - Over-temperature disables common output buffer.
// - Match seven-bit address, byte C0h.
// - Address pin sets one address bit.
// - Each channel takes an 8-bit code.
// - Control bits 5:4 select bias current.

`include "gbd_defs.svh"

module gbd_top #(
  parameter int NUM_CHAN = `GBD_NUM_CHAN
) (
  // Clock and reset.
  input  wire logic                 i_mclk,
  input  wire logic                 i_reset_n,
  // I2C bus, data line split into three signals.
  input  wire logic                 i_scl,
  input  wire logic                 i_sda,
  output logic                      o_sda_out,
  output logic                      o_sda_oe,
  // Control pins.
  input  wire logic                 i_output_load_strobe,
  input  wire logic                 i_bank_select_pin_low,
  input  wire logic                 i_bank_select_pin_high,
  input  wire logic                 i_address_select_pin,
  input  wire logic                 i_over_temp,
  // DAC codes and buffer controls.
  output gbd_pkg::gbd_dac_out_t     o_dac
);
  import gbd_pkg::*;

  if (NUM_CHAN != `GBD_NUM_CHAN) begin : g_chan_check
    $error("Channel count is fixed by the register map.");
  end

  // Reset release through two flip-flops.
  logic [1:0] rst_sync_ff;
  logic       rst_n;

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_ff[1];

  // Two-stage synchronisers for every pin.
  gbd_pins_t pin_meta_ff;
  gbd_pins_t pin_ff;
  logic      scl_prev_ff;
  logic      sda_prev_ff;

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_ff <= `GBD_PIN_IDLE;
      pin_ff      <= `GBD_PIN_IDLE;
      scl_prev_ff <= 1'b1;
      sda_prev_ff <= 1'b1;
    end else begin
      pin_meta_ff <= '{scl: i_scl, sda: i_sda, ld: i_output_load_strobe,
                       bank_hi: i_bank_select_pin_high, bank_lo: i_bank_select_pin_low,
                       addr_sel: i_address_select_pin, hot: i_over_temp};
      pin_ff      <= pin_meta_ff;
      scl_prev_ff <= pin_ff.scl;
      sda_prev_ff <= pin_ff.sda;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  assign scl_rise  = pin_ff.scl & ~scl_prev_ff;
  assign scl_fall  = ~pin_ff.scl & scl_prev_ff;
  assign bus_start = pin_ff.scl & scl_prev_ff & sda_prev_ff & ~pin_ff.sda;
  assign bus_stop  = pin_ff.scl & scl_prev_ff & ~sda_prev_ff & pin_ff.sda;

  // Register storage.
  gbd_code_t direct_ff [NUM_CHAN];
  gbd_code_t bank_ff   [NUM_CHAN*`GBD_NUM_BANK];
  logic [1:0] sw_bank_ff;
  logic       standby_ff;
  gbd_code_t  ctrl_ff;

  // Serial slave state.
  gbd_i2c_state_t state_ff;
  logic [3:0]     bitcnt_ff;
  gbd_code_t      shift_ff;
  gbd_code_t      tx_ff;
  gbd_code_t      ptr_ff;
  logic           read_ff;
  logic           sda_oe_ff;
  gbd_code_t      rd_data;
  logic           addr_match;
  logic           wr_commit;

  function automatic logic in_range(input gbd_code_t a, input gbd_code_t lo, input gbd_code_t hi);
    return (a >= lo) && (a <= hi);
  endfunction

  always_comb begin
    rd_data = 8'h00;
    if (in_range(ptr_ff, `GBD_ADDR_DIRECT, `GBD_ADDR_DIRECT_END)) begin
      rd_data = direct_ff[ptr_ff[3:0]];
    end else if (in_range(ptr_ff, `GBD_ADDR_BANK, `GBD_ADDR_BANK_END)) begin
      rd_data = bank_ff[6'(ptr_ff - `GBD_ADDR_BANK)];
    end else if (ptr_ff == `GBD_ADDR_SW_BANK) begin
      rd_data = {6'h00, sw_bank_ff};
    end else if (ptr_ff == `GBD_ADDR_STANDBY) begin
      rd_data = {7'h00, standby_ff};
    end else if (ptr_ff == `GBD_ADDR_STATUS) begin
      rd_data = {pin_ff.ld, 5'h00, pin_ff.bank_hi, pin_ff.bank_lo};
    end else if (ptr_ff == `GBD_ADDR_CTRL) begin
      rd_data = ctrl_ff;
    end
  end

  // Address byte: upper six bits fixed, address pin gives bit 0 of the address.
  assign addr_match = (shift_ff[7:1] == {`GBD_SLAVE_ADDR_HI, pin_ff.addr_sel});

  // A write lands when the master's clock falls at the end of the acknowledge bit.
  assign wr_commit = (state_ff == GBD_WACK) && scl_fall;

  // Serial slave sequencer; it never looks at the standby bit.
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff  <= GBD_IDLE;
      bitcnt_ff <= 4'h0;
      shift_ff  <= 8'h00;
      tx_ff     <= 8'h00;
      ptr_ff    <= 8'h00;
      read_ff   <= 1'b0;
      sda_oe_ff <= 1'b0;
    end else if (bus_start) begin
      state_ff  <= GBD_ADDR;
      bitcnt_ff <= 4'h0;
      sda_oe_ff <= 1'b0;
    end else if (bus_stop) begin
      state_ff  <= GBD_IDLE;
      sda_oe_ff <= 1'b0;
    end else if (scl_rise) begin
      case (state_ff)
        GBD_ADDR, GBD_REG, GBD_WDATA: begin
          shift_ff  <= {shift_ff[6:0], pin_ff.sda};
          bitcnt_ff <= bitcnt_ff + 4'h1;
        end
        GBD_RDATA: begin
          bitcnt_ff <= bitcnt_ff + 4'h1;
        end
        GBD_RACK: begin
          read_ff <= ~pin_ff.sda;
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      case (state_ff)
        GBD_ADDR: begin
          if (bitcnt_ff == 4'h8) begin
            if (addr_match) begin
              state_ff  <= GBD_ADDR_ACK;
              read_ff   <= shift_ff[0];
              sda_oe_ff <= 1'b1;
            end else begin
              state_ff <= GBD_IDLE;
            end
          end
        end
        GBD_ADDR_ACK: begin
          bitcnt_ff <= 4'h0;
          if (read_ff) begin
            state_ff  <= GBD_RDATA;
            tx_ff     <= {rd_data[6:0], 1'b0};
            sda_oe_ff <= ~rd_data[7];
            ptr_ff    <= ptr_ff + 8'h01;
          end else begin
            state_ff  <= GBD_REG;
            sda_oe_ff <= 1'b0;
          end
        end
        GBD_REG: begin
          if (bitcnt_ff == 4'h8) begin
            state_ff  <= GBD_REG_ACK;
            ptr_ff    <= shift_ff;
            sda_oe_ff <= 1'b1;
          end
        end
        GBD_REG_ACK, GBD_WACK: begin
          state_ff  <= GBD_WDATA;
          bitcnt_ff <= 4'h0;
          sda_oe_ff <= 1'b0;
          if (state_ff == GBD_WACK) begin
            ptr_ff <= ptr_ff + 8'h01;
          end
        end
        GBD_WDATA: begin
          if (bitcnt_ff == 4'h8) begin
            state_ff  <= GBD_WACK;
            sda_oe_ff <= 1'b1;
          end
        end
        GBD_RDATA: begin
          if (bitcnt_ff == 4'h8) begin
            state_ff  <= GBD_RACK;
            sda_oe_ff <= 1'b0;
          end else begin
            sda_oe_ff <= ~tx_ff[7];
            tx_ff     <= {tx_ff[6:0], 1'b0};
          end
        end
        GBD_RACK: begin
          bitcnt_ff <= 4'h0;
          if (read_ff) begin
            state_ff  <= GBD_RDATA;
            tx_ff     <= {rd_data[6:0], 1'b0};
            sda_oe_ff <= ~rd_data[7];
            ptr_ff    <= ptr_ff + 8'h01;
          end else begin
            state_ff <= GBD_IDLE;
          end
        end
        default: begin
          state_ff <= GBD_IDLE;
        end
      endcase
    end
  end

  assign o_sda_out = 1'b0;
  assign o_sda_oe  = sda_oe_ff;

  // Register writes; volatile value writes land at once with no write delay.
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_CHAN; i++) begin
        direct_ff[i] <= `GBD_RST_VOLATILE;
      end
      for (int i = 0; i < NUM_CHAN*`GBD_NUM_BANK; i++) begin
        bank_ff[i] <= `GBD_RST_BANK;
      end
      sw_bank_ff <= 2'h0;
      standby_ff <= 1'b0;
      ctrl_ff    <= `GBD_RST_CTRL;
    end else if (wr_commit) begin
      if (in_range(ptr_ff, `GBD_ADDR_DIRECT, `GBD_ADDR_DIRECT_END)) begin
        direct_ff[ptr_ff[3:0]] <= shift_ff;
      end else if (in_range(ptr_ff, `GBD_ADDR_BANK, `GBD_ADDR_BANK_END)) begin
        bank_ff[6'(ptr_ff - `GBD_ADDR_BANK)] <= shift_ff;
      end else if (ptr_ff == `GBD_ADDR_SW_BANK) begin
        sw_bank_ff <= shift_ff[1:0];
      end else if (ptr_ff == `GBD_ADDR_STANDBY) begin
        standby_ff <= shift_ff[`GBD_STANDBY_BIT];
      end else if (ptr_ff == `GBD_ADDR_CTRL) begin
        ctrl_ff <= shift_ff & `GBD_MASK_CTRL;
      end
    end
  end

  // Source selection for the output hold latch.
  logic [1:0] mode;
  logic [1:0] bank_sel;
  gbd_code_t  sel_code [NUM_CHAN];

  assign mode = ctrl_ff[`GBD_CTRL_MODE_LSB +: 2];

  always_comb begin
    if (mode == 2'b01) begin
      bank_sel = sw_bank_ff;
    end else begin
      bank_sel = {pin_ff.bank_hi, pin_ff.bank_lo};
    end
    for (int i = 0; i < NUM_CHAN; i++) begin
      if (mode[1]) begin
        sel_code[i] = direct_ff[i];
      end else begin
        sel_code[i] = bank_ff[i*`GBD_NUM_BANK + int'(bank_sel)];
      end
    end
  end

  // Output hold latch: follows while the strobe is high, holds while low.
  gbd_code_t latch_b_ff [NUM_CHAN];

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_CHAN; i++) begin
        latch_b_ff[i] <= `GBD_RST_VOLATILE;
      end
    end else if (pin_ff.ld) begin
      for (int i = 0; i < NUM_CHAN; i++) begin
        latch_b_ff[i] <= sel_code[i];
      end
    end
  end

  // Buffer enables registered toward the analog side; bias field taken straight from the control register.
  logic gamma_hiz_ff;
  logic common_hiz_ff;

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      gamma_hiz_ff  <= 1'b0;
      common_hiz_ff <= 1'b0;
    end else begin
      gamma_hiz_ff  <= standby_ff;
      common_hiz_ff <= standby_ff | pin_ff.hot;
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_CHAN; i++) begin
      o_dac.code[i] = latch_b_ff[i];
    end
    o_dac.gamma_hiz  = gamma_hiz_ff;
    o_dac.common_hiz = common_hiz_ff;
    o_dac.bias       = ctrl_ff[`GBD_CTRL_BIAS_LSB +: 2];
  end

  // Checks.
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!rst_n);

  a_reset_mode_bank: assert property ($rose(rst_n) |-> mode == 2'b00 && sw_bank_ff == 2'h0)
    else $error("Mode or software bank not cleared after reset.");
  a_pin_bank_sel: assert property (mode == 2'b00 |-> bank_sel == {pin_ff.bank_hi, pin_ff.bank_lo})
    else $error("Pin mode does not follow select pins.");
  a_soft_bank_sel: assert property (mode == 2'b01 |-> bank_sel == sw_bank_ff)
    else $error("Software mode does not follow select register.");
  a_direct_src_sel: assert property (mode[1] |-> sel_code[0] == direct_ff[0])
    else $error("Direct mode not using value register.");
  a_latch_flow_high: assert property (pin_ff.ld |=> o_dac.code[NUM_CHAN-1] == $past(sel_code[NUM_CHAN-1]))
    else $error("Output latch not transparent with strobe high.");
  a_latch_hold_low: assert property (!pin_ff.ld ##1 !pin_ff.ld |-> $stable(o_dac.code))
    else $error("Output latch changed with strobe low.");
  a_standby_output: assert property ($rose(standby_ff) |=> o_dac.gamma_hiz && o_dac.common_hiz)
    else $error("Standby did not float outputs.");
  a_hot_common_off: assert property (pin_ff.hot |=> o_dac.common_hiz)
    else $error("Common buffer not disabled when hot.");
  a_addr_ack_drive: assert property (state_ff == GBD_ADDR && scl_fall && bitcnt_ff == 4'h8 && addr_match && !bus_start
                                     && !bus_stop |=> state_ff == GBD_ADDR_ACK && o_sda_oe)
    else $error("Matching address not acknowledged.");
  a_standby_ack: assert property (standby_ff && state_ff == GBD_WDATA && scl_fall && bitcnt_ff == 4'h8
                                  && !bus_start && !bus_stop |=> o_sda_oe)
    else $error("Data byte not acknowledged in standby.");
  a_write_commit: assert property (wr_commit && ptr_ff == `GBD_ADDR_STANDBY
                                   |=> standby_ff == $past(shift_ff[0]))
    else $error("Standby write did not land after acknowledge.");

  c_soft_load: cover property (mode == 2'b01 && $rose(pin_ff.ld));
  c_direct_write: cover property (mode[1] && wr_commit && ptr_ff == `GBD_ADDR_DIRECT);
  c_read_byte: cover property (state_ff == GBD_RACK && scl_fall);
  c_standby_on: cover property ($rose(standby_ff));

endmodule // gbd_top

// File: verif/gbd_i2c_master.sv
// Bus master model that drives the clock and data lines of the register interface.
module gbd_i2c_master (
  // Clock and data line state.
  input  wire logic i_clk,
  input  wire logic i_oe,
  // Bus lines.
  output logic      o_scl,
  output logic      o_sda
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sda_m;
  initial begin
    o_scl = 1'b1;
    sda_m = 1'b1;
  end
  // The data line has a pull-up, so any party pulling low wins.
  assign o_sda = sda_m & ~i_oe;
  task automatic half();
    repeat (4) @(negedge i_clk);
  endtask
  task automatic bit_x(input logic b, output logic r);
    o_scl = 1'b0;
    @(negedge i_clk);
    sda_m = b;
    repeat (3) @(negedge i_clk);
    o_scl = 1'b1;
    half();
    r = o_sda;
  endtask
  task automatic cond(input logic lvl);
    o_scl = 1'b0;
    @(negedge i_clk);
    sda_m = ~lvl;
    repeat (3) @(negedge i_clk);
    o_scl = 1'b1;
    half();
    sda_m = lvl;
    half();
  endtask
  task automatic tx(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(b[i], r);
    bit_x(1'b1, r);
    ack = ~r;
  endtask
  task automatic wr(input logic [7:0] dev, input logic [7:0] ra, input logic [7:0] d, output logic ok);
    logic a1, a2, a3;
    cond(1'b0);
    tx(dev, a1);
    tx(ra, a2);
    tx(d, a3);
    cond(1'b1);
    ok = a1 & a2 & a3;
  endtask
  task automatic rd(input logic [7:0] dev, input logic [7:0] ra, output logic [7:0] d, output logic ok);
    logic a1, a2, a3, r;
    cond(1'b0);
    tx(dev, a1);
    tx(ra, a2);
    cond(1'b0);
    tx(dev | 8'h01, a3);
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, r);
      d[i] = r;
    end
    bit_x(1'b1, r);
    cond(1'b1);
    ok = a1 & a2 & a3;
  endtask
endmodule // gbd_i2c_master

// File: verif/test_gbd_top.sv
// Self-checking testbench of the gamma bank control block.
module test_gbd_top;
  timeunit 1ns;
  timeprecision 1ps;
  import gbd_pkg::*;
  logic          mclk, reset_n, ld, bank_lo, bank_hi, a0, hot, scl, sda, sda_out, sda_oe, ok;
  gbd_dac_out_t  dac;
  logic [7:0]    va[4] = '{8'h11, 8'h5a, 8'ha5, 8'hff};
  logic [7:0]    vb[4] = '{8'h01, 8'h7e, 8'h80, 8'hfe};
  int            n_mismatch = 0;
  int            n_compared = 0;
  gbd_top i_gbd_top (.i_mclk(mclk), .i_reset_n(reset_n), .i_scl(scl), .i_sda(sda), .o_sda_out(sda_out),
    .o_sda_oe(sda_oe), .i_output_load_strobe(ld), .i_bank_select_pin_low(bank_lo),
    .i_bank_select_pin_high(bank_hi), .i_address_select_pin(a0), .i_over_temp(hot), .o_dac(dac));
  gbd_i2c_master i_gbd_i2c_master (.i_clk(mclk), .i_oe(sda_oe), .o_scl(scl), .o_sda(sda));
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check8(input string n, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk1(input string n, input logic e, input logic g);
    check8(n, {7'h0, e}, {7'h0, g});
  endtask
  task automatic wreg(input logic [7:0] ra, input logic [7:0] d);
    i_gbd_i2c_master.wr(8'hc0, ra, d, ok);
    chk1("write ack", 1'b1, ok);
  endtask
  task automatic rreg(input logic [7:0] ra, input logic [7:0] e);
    logic [7:0] d;
    i_gbd_i2c_master.rd(8'hc0, ra, d, ok);
    chk1("read ack", 1'b1, ok);
    chk1("sda out level", 1'b0, sda_out);
    check8("read data", e, d);
  endtask
  task automatic codes(input logic [7:0] e0, input logic [7:0] e10);
    repeat (8) @(negedge mclk);
    check8("code 0", e0, dac.code[0]);
    check8("code 10", e10, dac.code[10]);
  endtask
  initial begin
    repeat (100000) @(posedge mclk);
    n_mismatch++;
    $display("[FAIL] run time expected below limit seen limit");
    complete_run();
  end
  initial begin
    {reset_n, ld, bank_lo, bank_hi, a0, hot} = 6'b010000;
    repeat (16) @(negedge mclk);
    reset_n = 1'b1;
    repeat (8) @(negedge mclk);
    rreg(8'h60, 8'h10);
    rreg(8'h50, 8'h00);
    rreg(8'h51, 8'h00);
    rreg(8'h00, 8'h00);
    codes(8'h80, 8'h80);
    check8("bias", 8'h01, {6'h0, dac.bias});
    for (int b = 0; b < 4; b++) begin
      wreg(8'h10 + 8'(b), va[b]);
      wreg(8'h38 + 8'(b), vb[b]);
    end
    for (int b = 0; b < 4; b++) begin
      {bank_hi, bank_lo} = 2'(b);
      codes(va[b], vb[b]);
    end
    ld = 1'b0;
    {bank_hi, bank_lo} = 2'd0;
    codes(va[3], vb[3]);
    ld = 1'b1;
    codes(va[0], vb[0]);
    ld = 1'b0;
    {bank_hi, bank_lo} = 2'd2;
    codes(va[0], vb[0]);
    ld = 1'b1;
    wreg(8'h60, 8'h11);
    rreg(8'h60, 8'h11);
    {bank_hi, bank_lo} = 2'd3;
    repeat (8) @(negedge mclk);
    rreg(8'h57, 8'h83);
    for (int b = 0; b < 4; b++) begin
      wreg(8'h50, 8'(b));
      codes(va[b], vb[b]);
    end
    wreg(8'h60, 8'h31);
    codes(va[3], vb[3]);
    check8("bias", 8'h03, {6'h0, dac.bias});
    wreg(8'h60, 8'h22);
    rreg(8'h60, 8'h22);
    codes(8'h00, 8'h00);
    check8("bias", 8'h02, {6'h0, dac.bias});
    wreg(8'h00, 8'hff);
    wreg(8'h0a, 8'h5a);
    codes(8'hff, 8'h5a);
    ld = 1'b0;
    wreg(8'h0a, 8'h3c);
    codes(8'hff, 8'h5a);
    ld = 1'b1;
    codes(8'hff, 8'h3c);
    rreg(8'h0a, 8'h3c);
    wreg(8'h60, 8'h23);
    codes(8'hff, 8'h3c);
    wreg(8'h51, 8'h01);
    repeat (8) @(negedge mclk);
    chk1("gamma hiz", 1'b1, dac.gamma_hiz);
    chk1("common hiz", 1'b1, dac.common_hiz);
    rreg(8'h51, 8'h01);
    wreg(8'h0a, 8'h66);
    wreg(8'h51, 8'h00);
    codes(8'hff, 8'h66);
    chk1("gamma hiz", 1'b0, dac.gamma_hiz);
    hot = 1'b1;
    repeat (8) @(negedge mclk);
    chk1("common hiz", 1'b1, dac.common_hiz);
    chk1("gamma hiz", 1'b0, dac.gamma_hiz);
    hot = 1'b0;
    repeat (8) @(negedge mclk);
    chk1("common hiz", 1'b0, dac.common_hiz);
    a0 = 1'b1;
    repeat (8) @(negedge mclk);
    i_gbd_i2c_master.wr(8'hc0, 8'h00, 8'h12, ok);
    chk1("wrong address ack", 1'b0, ok);
    i_gbd_i2c_master.wr(8'hc2, 8'h00, 8'h12, ok);
    chk1("second address ack", 1'b1, ok);
    codes(8'h12, 8'h66);
    complete_run();
  end
endmodule // test_gbd_top
